// [logic/sfsc_pkg.sv]
// Shared constants and types for the fan speed control block
package sfsc_pkg;
  // System clock and fan reference clock rates
  localparam int CLK_HZ = 250_000_000;
  localparam int REF_HZ = 32768;
  localparam int REF_DIV_CYC = CLK_HZ / REF_HZ;
  // Target count for rpm is RPM_COUNT_NUM / rpm at two pulses per revolution
  localparam int TACH_PULSES_PER_REV = 2;
  localparam int RPM_COUNT_NUM = (REF_HZ * 30) / TACH_PULSES_PER_REV;
  // PWM step divider, system cycles per duty step
  localparam int PWM_DIV_CYC = 32;
  // Command byte map
  localparam logic [7:0] CMD_TEMP_BASE = 8'h00;
  localparam logic [7:0] CMD_FAN_MEAS_BASE = 8'h08;
  localparam logic [7:0] CMD_FAN_TGT_BASE = 8'h0C;
  localparam logic [7:0] CMD_FAN_STAT = 8'h10;
  // Special values and reset values
  localparam logic [7:0] FAN_STOP_CNT = 8'hFF;
  localparam logic [7:0] FAN_TGT_RST = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;
  localparam logic [7:0] TEMP_POS_SAT = 8'h7F;
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h4C;
  // Serial slave states
  typedef enum logic [3:0] {
    SFSC_IDLE,
    SFSC_ADDR,
    SFSC_ADDR_ACK,
    SFSC_CMD,
    SFSC_CMD_ACK,
    SFSC_WDATA,
    SFSC_WDATA_ACK,
    SFSC_RDATA,
    SFSC_RDATA_ACK,
    SFSC_IGNORE
  } sfsc_state_e;
endpackage

// [logic/sfsc_fan_chan.sv]
// One fan channel: tachometer period measurement and PWM drive loop
`timescale 1ns/1ps
module sfsc_fan_chan (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ref_tick,
  input wire logic pwm_tick,
  input wire logic fan_tach_input,
  input wire logic [7:0] target,
  output logic [7:0] period,
  output logic fan_drive,
  output logic power_save
);
  logic tach_prev, next_tach_prev;
  logic [7:0] cnt, next_cnt;
  logic [7:0] next_period;
  logic [7:0] duty, next_duty;
  logic [7:0] pwm_cnt, next_pwm_cnt;
  logic next_fan_drive, next_power_save;
  logic tach_rise, stop;

  assign tach_rise = fan_tach_input && !tach_prev;
  assign stop = (target == sfsc_pkg::FAN_STOP_CNT);

  // Period count, duty loop and PWM output
  always_comb begin
    next_tach_prev = fan_tach_input;
    next_cnt = cnt;
    next_period = period;
    next_duty = duty;
    next_pwm_cnt = pwm_cnt;
    if (ref_tick && cnt != 8'hFF) begin
      next_cnt = cnt + 8'h01; // Reference periods since last edge
    end
    if (tach_rise) begin
      next_period = cnt; // Period count, not speed
      next_cnt = 8'h00;
      // Slower than target raises duty, faster lowers it
      if (cnt > target && duty != 8'hFF) begin
        next_duty = duty + 8'h01;
      end else if (cnt < target && duty != 8'h00) begin
        next_duty = duty - 8'h01;
      end
    end else if (cnt == 8'hFF) begin
      next_period = 8'hFF; // Stalled fan reads full scale
      if (ref_tick && duty != 8'hFF) begin
        next_duty = duty + 8'h01;
      end
    end
    if (pwm_tick) begin
      next_pwm_cnt = pwm_cnt + 8'h01;
    end
    next_fan_drive = (duty > pwm_cnt);
    next_power_save = 1'b0;
    if (stop) begin
      next_duty = 8'h00; // Stop code halts drive, idles loop
      next_fan_drive = 1'b0;
      next_power_save = 1'b1;
      next_pwm_cnt = 8'h00;
    end
  end

  // Channel state registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tach_prev <= 1'b0;
      cnt <= 8'h00;
      period <= 8'hFF;
      duty <= 8'h00;
      pwm_cnt <= 8'h00;
      fan_drive <= 1'b0;
      power_save <= 1'b1;
    end else begin
      tach_prev <= next_tach_prev;
      cnt <= next_cnt;
      period <= next_period;
      duty <= next_duty;
      pwm_cnt <= next_pwm_cnt;
      fan_drive <= next_fan_drive;
      power_save <= next_power_save;
    end
  end
endmodule

// [logic/sfsc_top.sv]
// Fan speed controller with temperature readout behind an SMBus slave
// How it works
// - Tach period counted in reference clock periods
// - Loop compares measured and target counts directly
// - 32768 Hz, two pulses: count 491520/rpm
// - Target 255 stops fan, power save
// - All data seen as 8-bit registers
// - Every channel answers one slave address
// - Write, Read, Send, Receive Byte only
// - Receive Byte reads last commanded register
// - Temperature: two's complement, 1 C, MSB first
// - Half-degree offset added before truncating
`timescale 1ns/1ps
module sfsc_top #(
  parameter int N_FAN = 2,
  parameter int N_TEMP = 3,
  parameter int REF_DIV = sfsc_pkg::REF_DIV_CYC,
  parameter logic [6:0] SLAVE_ADDR = sfsc_pkg::SLAVE_ADDR_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [8:0] temp_half [N_TEMP],
  input wire logic [N_FAN-1:0] fan_tach_input,
  output logic [N_FAN-1:0] fan_drive,
  output logic [N_FAN-1:0] fan_power_save
);
  // Reference tick and PWM step dividers
  logic [15:0] ref_div, next_ref_div;
  logic [7:0] pwm_div, next_pwm_div;
  logic ref_tick, pwm_tick;
  assign ref_tick = (ref_div == 16'(REF_DIV - 1)); // 32768 Hz tick for counts
  assign pwm_tick = (pwm_div == 8'(sfsc_pkg::PWM_DIV_CYC - 1));

  always_comb begin
    next_ref_div = ref_tick ? 16'h0000 : ref_div + 16'h0001;
    next_pwm_div = pwm_tick ? 8'h00 : pwm_div + 8'h01;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_div <= 16'h0000;
      pwm_div <= 8'h00;
    end else begin
      ref_div <= next_ref_div;
      pwm_div <= next_pwm_div;
    end
  end

  // Rounded temperature registers
  logic [7:0] temp_reg [N_TEMP];
  logic [7:0] next_temp [N_TEMP];
  logic [9:0] temp_sum [N_TEMP];

  always_comb begin
    for (int i = 0; i < N_TEMP; i++) begin
      temp_sum[i] = {temp_half[i][8], temp_half[i]} + 10'h001; // Add half degree
      if (temp_sum[i][9] != temp_sum[i][8]) begin
        next_temp[i] = sfsc_pkg::TEMP_POS_SAT;
      end else begin
        next_temp[i] = temp_sum[i][8:1]; // Truncate to 1 C two's complement
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N_TEMP; i++) begin
        temp_reg[i] <= 8'h00;
      end
    end else begin
      temp_reg <= next_temp;
    end
  end

  // Fan target registers, written by Write Byte
  logic [7:0] fan_tgt [N_FAN];
  logic [7:0] next_fan_tgt [N_FAN];
  logic [7:0] fan_period [N_FAN];
  logic wr_en;
  logic [7:0] wr_cmd, wr_data;

  always_comb begin
    for (int i = 0; i < N_FAN; i++) begin
      next_fan_tgt[i] = fan_tgt[i];
      if (wr_en && wr_cmd == sfsc_pkg::CMD_FAN_TGT_BASE + 8'(i)) begin
        next_fan_tgt[i] = wr_data; // Host supplies period count target
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N_FAN; i++) begin
        fan_tgt[i] <= sfsc_pkg::FAN_TGT_RST;
      end
    end else begin
      fan_tgt <= next_fan_tgt;
    end
  end

  // Fan channels
  genvar g;
  generate
    for (g = 0; g < N_FAN; g++) begin : gen_fan
      sfsc_fan_chan u_chan (
        .ref_clk(ref_clk),
        .rst(rst),
        .ref_tick(ref_tick),
        .pwm_tick(pwm_tick),
        .fan_tach_input(fan_tach_input[g]),
        .target(fan_tgt[g]),
        .period(fan_period[g]),
        .fan_drive(fan_drive[g]),
        .power_save(fan_power_save[g])
      );
    end
  endgenerate

  // Byte-wide register read map
  logic [7:0] cmd_ptr;
  logic [7:0] rd_data;
  always_comb begin
    rd_data = sfsc_pkg::UNMAPPED_READ;
    for (int i = 0; i < N_TEMP; i++) begin
      if (cmd_ptr == sfsc_pkg::CMD_TEMP_BASE + 8'(i)) rd_data = temp_reg[i];
    end
    for (int i = 0; i < N_FAN; i++) begin
      if (cmd_ptr == sfsc_pkg::CMD_FAN_MEAS_BASE + 8'(i)) rd_data = fan_period[i];
      if (cmd_ptr == sfsc_pkg::CMD_FAN_TGT_BASE + 8'(i)) rd_data = fan_tgt[i];
    end
    if (cmd_ptr == sfsc_pkg::CMD_FAN_STAT) begin
      rd_data = 8'(fan_power_save);
    end
  end

  // SMBus slave state
  sfsc_pkg::sfsc_state_e state, next_state;
  logic scl_prev, sda_prev;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] next_cmd_ptr;
  logic next_sda_oe;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  assign scl_rise = scl_in && !scl_prev;
  assign scl_fall = !scl_in && scl_prev;
  assign start_cond = scl_in && scl_prev && sda_prev && !sda_in;
  assign stop_cond = scl_in && scl_prev && !sda_prev && sda_in;
  assign sda_out = 1'b0; // Open drain, only ever pulls low

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_cmd_ptr = cmd_ptr;
    next_sda_oe = sda_oe;
    wr_en = 1'b0;
    wr_cmd = cmd_ptr;
    wr_data = shreg;
    if (start_cond) begin
      next_state = sfsc_pkg::SFSC_ADDR; // Start or repeated start
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_state = sfsc_pkg::SFSC_IDLE;
      next_sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (state)
        sfsc_pkg::SFSC_ADDR, sfsc_pkg::SFSC_CMD, sfsc_pkg::SFSC_WDATA: begin
          next_shreg = {shreg[6:0], sda_in};
          next_bit_cnt = bit_cnt + 4'h1;
        end
        sfsc_pkg::SFSC_RDATA: begin
          next_bit_cnt = bit_cnt + 4'h1;
        end
        sfsc_pkg::SFSC_RDATA_ACK: begin
          // Master ack asks for the same register again, nack ends
          next_state = sda_in ? sfsc_pkg::SFSC_IGNORE : sfsc_pkg::SFSC_RDATA_ACK;
        end
        default: begin
          next_state = state;
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        sfsc_pkg::SFSC_ADDR: begin
          if (bit_cnt == 4'h8) begin
            if (shreg[7:1] == SLAVE_ADDR) begin
              next_state = sfsc_pkg::SFSC_ADDR_ACK; // One address for all channels
              next_sda_oe = 1'b1; // Address ack
            end else begin
              next_state = sfsc_pkg::SFSC_IGNORE;
            end
          end
        end
        sfsc_pkg::SFSC_ADDR_ACK: begin
          next_bit_cnt = 4'h0;
          if (shreg[0]) begin
            // Read Byte after repeated start, or Receive Byte
            next_state = sfsc_pkg::SFSC_RDATA;
            next_shreg = {rd_data[6:0], 1'b0};
            next_sda_oe = !rd_data[7]; // MSB first
          end else begin
            next_state = sfsc_pkg::SFSC_CMD; // Write, Send or Read Byte command
            next_sda_oe = 1'b0;
          end
        end
        sfsc_pkg::SFSC_CMD: begin
          if (bit_cnt == 4'h8) begin
            next_cmd_ptr = shreg; // Kept for later Receive Byte
            next_state = sfsc_pkg::SFSC_CMD_ACK;
            next_sda_oe = 1'b1; // Command ack
          end
        end
        sfsc_pkg::SFSC_CMD_ACK: begin
          next_state = sfsc_pkg::SFSC_WDATA;
          next_bit_cnt = 4'h0;
          next_sda_oe = 1'b0;
        end
        sfsc_pkg::SFSC_WDATA: begin
          if (bit_cnt == 4'h8) begin
            wr_en = 1'b1; // Write Byte data lands
            next_state = sfsc_pkg::SFSC_WDATA_ACK;
            next_sda_oe = 1'b1; // Data ack
          end
        end
        sfsc_pkg::SFSC_WDATA_ACK: begin
          next_state = sfsc_pkg::SFSC_IGNORE; // Only one data byte
          next_sda_oe = 1'b0;
        end
        sfsc_pkg::SFSC_RDATA: begin
          if (bit_cnt == 4'h8) begin
            next_state = sfsc_pkg::SFSC_RDATA_ACK;
            next_sda_oe = 1'b0;
          end else begin
            next_sda_oe = !shreg[7]; // Next bit, MSB first
            next_shreg = {shreg[6:0], 1'b0};
          end
        end
        sfsc_pkg::SFSC_RDATA_ACK: begin
          next_state = sfsc_pkg::SFSC_RDATA;
          next_bit_cnt = 4'h0;
          next_shreg = {rd_data[6:0], 1'b0};
          next_sda_oe = !rd_data[7];
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= sfsc_pkg::SFSC_IDLE;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      cmd_ptr <= 8'h00;
      sda_oe <= 1'b0;
    end else begin
      state <= next_state;
      scl_prev <= scl_in;
      sda_prev <= sda_in;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      cmd_ptr <= next_cmd_ptr;
      sda_oe <= next_sda_oe;
    end
  end
endmodule

// [verification/sfsc_tach_model.sv]
// Fan tachometer model: square wave with a fixed period
`timescale 1ns/1ps
module sfsc_tach_model #(
  parameter int HALF = 80
) (
  input wire logic ref_clk,
  output logic tach
);
  // Free-running pulse train, one rising edge per period
  initial begin
    tach = 1'b0;
    forever begin
      repeat (HALF) @(negedge ref_clk);
      tach = ~tach;
    end
  end
endmodule

// [verification/sfsc_top_asserts.sv]
// Port assertions for the fan speed controller
`timescale 1ns/1ps
module sfsc_top_asserts #(
  parameter int N_FAN = 2,
  parameter int N_TEMP = 3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [8:0] temp_half [N_TEMP],
  input wire logic [N_FAN-1:0] fan_tach_input,
  input wire logic [N_FAN-1:0] fan_drive,
  input wire logic [N_FAN-1:0] fan_power_save
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Bus pin only pulls low
  a_sda_out_low: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("sda_oe rose with scl high");
  a_oe_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda_oe moved while scl high");
  a_start_clear: assert property ($fell(sda_in) && scl_in && $past(scl_in) |=> !sda_oe)
    else $error("sda_oe set after start");
  a_stop_clear: assert property ($rose(sda_in) && scl_in && $past(scl_in) |=> !sda_oe)
    else $error("sda_oe set after stop");
  // Fan state
  a_stop_no_drive: assert property ((fan_drive & fan_power_save) == '0)
    else $error("fan driven in power save");
  a_reset_state: assert property ($fell(rst) |-> fan_power_save == '1 && fan_drive == '0)
    else $error("fan state wrong after reset");
  a_save_on_fall: assert property ($changed(fan_power_save) |-> !scl_in)
    else $error("power save changed off a bus write");
endmodule
bind sfsc_top sfsc_top_asserts #(.N_FAN(N_FAN), .N_TEMP(N_TEMP)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .temp_half(temp_half), .fan_tach_input(fan_tach_input),
  .fan_drive(fan_drive), .fan_power_save(fan_power_save));

// [verification/tb.sv]
// Self-checking bench for the fan speed controller
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] ADDR = sfsc_pkg::SLAVE_ADDR_DEF;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic scl = 1'b1;
  logic host_sda = 1'b1;
  logic sda_out;
  logic sda_oe;
  logic sda_wire;
  logic [8:0] temp_half [3] = '{9'h0C7, 9'h1FF, 9'h1FD};
  logic [7:0] tx [3] = '{8'h64, 8'h00, 8'hFF};
  logic [1:0] tach;
  logic [1:0] fan_drive;
  logic [1:0] fan_power_save;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  // Open-drain wire with pull-up
  assign sda_wire = host_sda & ~sda_oe;
  always #2 ref_clk = ~ref_clk;
  sfsc_top #(.REF_DIV(4)) DUT (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .temp_half(temp_half), .fan_tach_input(tach),
    .fan_drive(fan_drive), .fan_power_save(fan_power_save));
  sfsc_tach_model #(.HALF(80)) u_t0 (.ref_clk(ref_clk), .tach(tach[0]));
  sfsc_tach_model #(.HALF(60)) u_t1 (.ref_clk(ref_clk), .tach(tach[1]));
  task automatic close_out();
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // One SCL pulse, data set while clock low
  task automatic bit_x(input logic b, output logic r);
    host_sda = b;
    tick(3);
    scl = 1'b1;
    tick(3);
    r = sda_wire;
    tick(3);
    scl = 1'b0;
    tick(3);
  endtask
  task automatic start();
    host_sda = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(6);
    host_sda = 1'b0;
    tick(6);
    scl = 1'b0;
    tick(3);
  endtask
  task automatic stop();
    host_sda = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(6);
    host_sda = 1'b1;
    tick(6);
  endtask
  task automatic send(input logic [7:0] d, input logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    check("ack", {7'h00, r}, {7'h00, nak});
  endtask
  // Master ack asks for another byte, nack ends the read
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!more, r);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    start();
    send({ADDR, 1'b0}, 1'b0);
    send(c, 1'b0);
    send(v, 1'b0);
    stop();
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    start();
    send({ADDR, 1'b0}, 1'b0);
    send(c, 1'b0);
    start();
    send({ADDR, 1'b1}, 1'b0);
    recv(1'b0, d);
    stop();
  endtask
  task automatic rcv(output logic [7:0] d);
    start();
    send({ADDR, 1'b1}, 1'b0);
    recv(1'b0, d);
    stop();
  endtask
  task automatic t_reset();
    logic [7:0] d;
    check("save", {6'h00, fan_power_save}, 8'h03);
    check("drive", {6'h00, fan_drive}, 8'h00);
    rd(sfsc_pkg::CMD_FAN_TGT_BASE, d);
    check("target", d, 8'hFF);
  endtask
  task automatic t_temp();
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      rd(sfsc_pkg::CMD_TEMP_BASE + 8'(i), d);
      check("temp", d, tx[i]);
    end
    temp_half[1] = 9'h0FF; // 127.5 C rounds past the top and saturates
    tick(2);
    rd(sfsc_pkg::CMD_TEMP_BASE + 8'h01, d);
    check("temp sat", d, sfsc_pkg::TEMP_POS_SAT);
    temp_half[1] = 9'h1FF;
  endtask
  // Send Byte sets pointer, Receive Byte follows it; stranger address ignored
  task automatic t_short();
    logic [7:0] d;
    start();
    send({ADDR, 1'b0}, 1'b0);
    send(sfsc_pkg::CMD_TEMP_BASE, 1'b0);
    stop();
    rcv(d);
    check("recv", d, tx[0]);
    // Master ack gives the same register again
    start();
    send({ADDR, 1'b1}, 1'b0);
    recv(1'b1, d);
    check("recv more", d, tx[0]);
    recv(1'b0, d);
    check("recv again", d, tx[0]);
    stop();
    wr(sfsc_pkg::CMD_FAN_TGT_BASE + 8'h01, 8'hFF);
    rcv(d); // Pointer replaced by another transaction
    check("recv ptr", d, 8'hFF);
    start();
    send({ADDR ^ 7'h01, 1'b0}, 1'b1);
    stop();
  endtask
  task automatic t_fan();
    logic [7:0] d;
    int k;
    tick(2000);
    rd(sfsc_pkg::CMD_FAN_MEAS_BASE, d);
    check("period0", {7'h00, d >= 8'h27 && d <= 8'h29}, 8'h01);
    rd(sfsc_pkg::CMD_FAN_MEAS_BASE + 8'h01, d);
    check("period1", {7'h00, d >= 8'h1D && d <= 8'h1F}, 8'h01);
    check("rpm count", 8'((sfsc_pkg::RPM_COUNT_NUM + 1000) / 2000), 8'hF6);
    wr(sfsc_pkg::CMD_FAN_TGT_BASE, 8'h14);
    tick(2);
    check("save run", {6'h00, fan_power_save}, 8'h02);
    for (k = 0; k < 20000 && fan_drive[0] !== 1'b1; k++) tick(1);
    check("drive up", {7'h00, fan_drive[0]}, 8'h01);
    wr(sfsc_pkg::CMD_FAN_TGT_BASE, sfsc_pkg::FAN_STOP_CNT);
    tick(2);
    check("drive off", {6'h00, fan_drive}, 8'h00);
    rd(sfsc_pkg::CMD_FAN_STAT, d);
    check("status", d, 8'h03);
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    tick(5);
    rst = 1'b0;
    tick(3);
    t_reset();
    t_temp();
    t_short();
    t_fan();
    close_out();
  end
endmodule
